/* rtl/spi_clock_cfg.svh */
/*
 * Register offsets, field positions, reset values and divider figures for the
 * serial clock and frame control block.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef SPI_CLOCK_CFG_SVH
`define SPI_CLOCK_CFG_SVH

`define CTRL_ONE_ADDR 4'h0
`define CTRL_TWO_ADDR 4'h4
`define STATUS_ADDR 4'h8
`define CTRL_ONE_RESET 16'h0000
`define CTRL_TWO_RESET 16'h0000
`define CTRL_ONE_MASK 16'h1fff
`define CTRL_TWO_MASK 16'he002
`define SS_ENABLE_BIT 7
`define IDLE_POL_BIT 6
`define MASTER_BIT 5
`define SEC_LSB 2
`define PRI_LSB 0
`define EDGE_SEL_BIT 8
`define FRAMED_BIT 15
`define SYNC_DIR_BIT 14
`define SYNC_POL_BIT 13
`define FRAME_DELAY_BIT 1
`define MAX_DIV_RATIO 512

`endif

/* rtl/spi_clock_pkg.sv */
/*
 * Types shared by the serial clock and frame control block.
 * Assumes the constants header is available on the include path.
 */
package spi_clock_pkg;
   `include "spi_clock_cfg.svh"

   typedef struct packed {
      logic framed_enable;
      logic sync_direction;
      logic sync_polarity;
      logic frame_delay;
   } frame_cfg_s;

   typedef struct packed {
      logic slave_select_pin_enable;
      logic clock_idle_polarity;
      logic master_select;
      logic edge_select;
      logic [2:0] secondary_prescale;
      logic [1:0] primary_prescale;
   } clock_cfg_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_BAD = 3'b100
   } gen_state_e;
endpackage

/* rtl/prescale_ratio.sv */
/*
 * Decodes the two prescale fields into the total divide ratio.
 * Assumes fields come straight from the control register.
 */
`timescale 1ns/1ps
module prescale_ratio
   import spi_clock_pkg::*;
(
   // Fields
   input wire logic [1:0] primary_prescale_i,
   input wire logic [2:0] secondary_prescale_i,
   // Ratio
   output logic [9:0] ratio_o
);
   function automatic logic [6:0] primary_ratio(input logic [1:0] code);
      case (code)
         2'h3: primary_ratio = 7'h01;
         2'h2: primary_ratio = 7'h04;
         2'h1: primary_ratio = 7'h10;
         default: primary_ratio = 7'h40;
      endcase
   endfunction

   logic [3:0] sec;
   assign sec = 4'h8 - {1'b0, secondary_prescale_i};
   assign ratio_o = 10'(primary_ratio(primary_prescale_i) * sec);
endmodule

/* rtl/sck_divider.sv */
/*
 * Divides the system clock into a serial clock of the given ratio.
 * Assumes the ratio is at least 2; a ratio of 1 is refused by the caller.
 */
`timescale 1ns/1ps
module sck_divider
   import spi_clock_pkg::*;
#(
   parameter int RATIO_W = 10
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic run_i,
   input wire logic [RATIO_W-1:0] ratio_i,
   // Output
   output logic active_o
);
   initial begin
      if (RATIO_W < 10) $error("ratio width too small");
   end

   logic [RATIO_W-1:0] count;
   logic [RATIO_W-1:0] half;
   assign half = ratio_i >> 1;

   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         count <= '0;
      end else if (count >= ratio_i - 1'b1) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end

   // Odd ratios give a short active phase; duty cycle is traded for simplicity.
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         active_o <= 1'b0;
      end else begin
         active_o <= (count < half);
      end
   end
endmodule

/* rtl/spi_clock_and_frame_control.sv */
/*
 * Control registers, serial clock generation and slave-select steering for one
 * serial port, reached over a classic Wishbone slave with 32-bit data.
 * Control one holds the clock shape and prescalers, control two the frame fields,
 * and a read-only status word reports the decoded ratio and the generator state.
 * Only byte lanes 0 and 1 are used; each register is a 16-bit halfword.
 * Assumes a single 100 MHz clock and a synchronous active-high reset, a master that
 * holds each request until it sees ack, and a shift engine outside this block that
 * consumes the serial clock, the edge select and the frame fields.
 */
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Bit 6 sets clock idle level: 1 idles high, 0 idles low.
// - Secondary prescale bits 4:2; code 111 divides 1, down to 000 dividing 8.
// - Primary prescale bits 1:0; codes 11,10,01,00 divide 1,4,16,64.
// - Prescalers shape the serial clock only in master mode.
// - Framed modes ignore clock edge select; software writes it as 0.
// - Control two: bits 15,14,13,1 read/write reset 0; others read 0.
module spi_clock_and_frame_control
   import spi_clock_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Port enable and link
   input wire logic port_enable_i,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_o,
   output logic slave_select_used_o,
   output logic edge_select_o,
   output frame_cfg_s frame_cfg_o
);
   localparam int RATIO_W = 10;
   localparam int STATUS_W = RATIO_W + 4;

   logic [15:0] ctrl_one;
   logic [15:0] ctrl_two;
   clock_cfg_s ccfg;
   gen_state_e state;
   gen_state_e next_state;
   logic [RATIO_W-1:0] ratio;
   logic active;
   logic bad_ratio;
   logic req;
   logic rd_req;
   logic [1:0] lane_wr;
   logic one_wr;
   logic two_wr;
   logic [STATUS_W-1:0] status_word;
   logic [3:0] frame_bits;
   logic gen_run;
   logic drive_clock;
   logic unused_in;

   // Refuse constants that the fixed-width logic below cannot serve.
   generate
      if ((1 << RATIO_W) <= `MAX_DIV_RATIO) begin : g_ratio_width
         $error("ratio width cannot hold the largest divide ratio");
      end
      if (STATUS_W + 18 != 32) begin : g_status_width
         $error("status word does not fill the read data bus");
      end
      if (`SEC_LSB + 2 >= `MASTER_BIT) begin : g_sec_field
         $error("secondary prescale field overlaps the master select bit");
      end
      if (`PRI_LSB + 1 >= `SEC_LSB) begin : g_pri_field
         $error("primary prescale field overlaps the secondary field");
      end
      if (`CTRL_ONE_ADDR == `CTRL_TWO_ADDR) begin : g_addr_clash
         $error("control registers share one address");
      end
      if (`STATUS_ADDR == `CTRL_ONE_ADDR || `STATUS_ADDR == `CTRL_TWO_ADDR) begin : g_stat_clash
         $error("status word shares an address with a control register");
      end
      if (`EDGE_SEL_BIT > 12) begin : g_edge_bit
         $error("edge select bit lies outside the writable field");
      end
      if (`FRAMED_BIT > 15) begin : g_framed_bit
         $error("framed enable bit lies outside the register");
      end
      if (`FRAME_DELAY_BIT >= `SYNC_POL_BIT) begin : g_delay_bit
         $error("frame delay bit must sit below the sync polarity bit");
      end
      if (`IDLE_POL_BIT == `MASTER_BIT) begin : g_pol_bit
         $error("idle polarity and master select share one bit");
      end
   endgenerate

   // A request is taken only while ack is low, so a held strobe is answered every other cycle, never twice in a row.
   assign req = cyc_i && stb_i && !ack_o;
   assign rd_req = req && !we_i;

   function automatic logic addr_hit(input logic [3:0] adr, input logic [3:0] target);
      addr_hit = (adr == target);
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [1:0] lanes, input logic [15:0] m);
      logic [15:0] v;
      v = old;
      if (lanes[0]) begin
         v[7:0] = d[7:0];
      end
      if (lanes[1]) begin
         v[15:8] = d[15:8];
      end
      merge = v & m;
   endfunction

   function automatic logic [31:0] read_word(input logic [3:0] adr, input logic [15:0] one,
                                             input logic [15:0] two,
                                             input logic [STATUS_W-1:0] stat);
      read_word = 32'h0;
      if (addr_hit(adr, `CTRL_ONE_ADDR)) begin
         read_word = {16'h0, one};
      end
      if (addr_hit(adr, `CTRL_TWO_ADDR)) begin
         read_word = {16'h0, two};
      end
      if (addr_hit(adr, `STATUS_ADDR)) begin
         read_word = {18'h0, stat};
      end
   endfunction

   function automatic clock_cfg_s unpack_one(input logic [15:0] r);
      clock_cfg_s c;
      c.slave_select_pin_enable = r[`SS_ENABLE_BIT];
      c.clock_idle_polarity = r[`IDLE_POL_BIT];
      c.master_select = r[`MASTER_BIT];
      c.edge_select = r[`EDGE_SEL_BIT];
      c.secondary_prescale = r[`SEC_LSB+2:`SEC_LSB];
      c.primary_prescale = r[`PRI_LSB+1:`PRI_LSB];
      unpack_one = c;
   endfunction

   // Only the two low byte lanes reach a 16-bit register; upper lanes carry nothing.
   genvar ln;
   generate
      for (ln = 0; ln < 2; ln++) begin : g_lane
         assign lane_wr[ln] = req && we_i && sel_i[ln];
      end
   endgenerate

   assign one_wr = (|lane_wr) && addr_hit(adr_i, `CTRL_ONE_ADDR);
   assign two_wr = (|lane_wr) && addr_hit(adr_i, `CTRL_TWO_ADDR);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_one <= `CTRL_ONE_RESET;
      end else if (one_wr) begin
         ctrl_one <= merge(ctrl_one, dat_i, lane_wr, `CTRL_ONE_MASK);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_two <= `CTRL_TWO_RESET;
      end else if (two_wr) begin
         ctrl_two <= merge(ctrl_two, dat_i, lane_wr, `CTRL_TWO_MASK);
      end
   end

   // Status packs the refusal flag, the one-hot generator state and the decoded ratio.
   assign status_word = {bad_ratio, state, ratio};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0;
      end else if (rd_req) begin
         dat_o <= read_word(adr_i, ctrl_one, ctrl_two, status_word);
      end
   end

   assign ccfg = unpack_one(ctrl_one);

   // Frame fields are gathered in struct order: enable, direction, polarity, delay.
   localparam int FRAME_POS [4] = '{`FRAME_DELAY_BIT, `SYNC_POL_BIT, `SYNC_DIR_BIT,
                                   `FRAMED_BIT};
   genvar fb;
   generate
      for (fb = 0; fb < 4; fb++) begin : g_frame
         assign frame_bits[fb] = ctrl_two[FRAME_POS[fb]];
      end
   endgenerate
   assign frame_cfg_o = frame_bits;

   // Edge select is forced low in framed mode so a stale value cannot leak.
   always_comb begin
      edge_select_o = ccfg.edge_select;
      if (frame_cfg_o.framed_enable) begin
         edge_select_o = 1'b0;
      end
   end

   // Slave select counts only in slave mode outside framed mode, guarding a misprogram.
   always_comb begin
      slave_select_used_o = 1'b0;
      if (ccfg.slave_select_pin_enable && !ccfg.master_select) begin
         slave_select_used_o = !frame_cfg_o.framed_enable;
      end
   end

   prescale_ratio u_ratio (
      .primary_prescale_i(ccfg.primary_prescale),
      .secondary_prescale_i(ccfg.secondary_prescale),
      .ratio_o(ratio)
   );

   // A 1:1 total cannot be generated; the generator parks in ST_BAD instead.
   assign bad_ratio = (ratio == 10'h1);

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (port_enable_i && ccfg.master_select) begin
               if (bad_ratio) begin
                  next_state = ST_BAD;
               end else begin
                  next_state = ST_RUN;
               end
            end
         end
         ST_RUN: begin
            if (!port_enable_i || !ccfg.master_select) begin
               next_state = ST_IDLE;
            end else if (bad_ratio) begin
               next_state = ST_IDLE;
            end
         end
         ST_BAD: begin
            // Leaving through idle lets a repaired ratio restart the divider cleanly.
            if (!port_enable_i || !ccfg.master_select) begin
               next_state = ST_IDLE;
            end else if (!bad_ratio) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign gen_run = (state == ST_RUN);
   assign drive_clock = port_enable_i && ccfg.master_select;

   sck_divider #(.RATIO_W(RATIO_W)) u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(gen_run),
      .ratio_i(ratio),
      .active_o(active)
   );

   // The idle level falls out of the xor, so a stopped divider parks at the polarity.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_o <= 1'b0;
      end else begin
         sck_o <= active ^ ccfg.clock_idle_polarity;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_oe_o <= 1'b0;
      end else begin
         sck_oe_o <= drive_clock;
      end
   end

   // The incoming clock is consumed by the shift engine, which lives outside this block.
   assign unused_in = sck_i;
endmodule

/* verif/spi_link_peer.sv */
/* Far-end controller that clocks the link while the block is a slave.
   Assumes run_i is raised only while the block does not drive the clock. */
`timescale 1ns/1ps
module spi_link_peer (
   // Control
   input wire logic clk_i,
   input wire logic run_i,
   input wire logic idle_i,
   // Link
   output logic sck_o
);
   logic [1:0] div;
   // The clock stands still at its idle level outside frames.
   always_ff @(posedge clk_i) begin
      if (!run_i) begin
         div <= 2'h0;
         sck_o <= idle_i;
      end else begin
         div <= div + 2'h1;
         if (div == 2'h3) sck_o <= !sck_o;
      end
   end
endmodule

/* verif/spi_clock_chk.sv */
/* Checker for the serial clock and frame control block.
   Assumes it is bound to the top module and that writes land by the ack edge. */
`timescale 1ns/1ps
module spi_clock_chk
   import spi_clock_pkg::*;
(
   // Watched ports
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic ack_o,
   input wire logic port_enable_i,
   input wire logic sck_o,
   input wire logic sck_oe_o,
   input wire logic slave_select_used_o,
   input wire logic edge_select_o,
   input wire frame_cfg_s frame_cfg_o
);
   logic [8:0] c1;
   logic [9:0] cnt;
   logic [9:0] ratio;
   logic seen;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   assign ratio = 10'(1 << (2 * (3 - c1[1:0]))) * 10'(8 - c1[4:2]);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         c1 <= 9'h000;
      end else if (cyc_i && stb_i && we_i && ack_o && adr_i == 4'h0) begin
         if (sel_i[0]) c1[7:0] <= dat_i[7:0];
         if (sel_i[1]) c1[8] <= dat_i[8];
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || !port_enable_i || !c1[5]) begin
         cnt <= 10'h000;
         seen <= 1'b0;
      end else if ($rose(sck_o)) begin
         cnt <= 10'h001;
         seen <= 1'b1;
      end else begin
         cnt <= cnt + 10'h001;
      end
   end
   sequence s_calm;
      ($stable(c1) && $stable(port_enable_i)) [*3];
   endsequence
   property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   property p_ack_one; ack_o |=> !ack_o; endproperty
   property p_idle; s_calm ##0 !port_enable_i |-> sck_o == c1[6]; endproperty
   property p_oe; s_calm |-> sck_oe_o == (port_enable_i && c1[5]); endproperty
   // Ties are judged only while ack is low, so either write edge passes.
   property p_ss;
      !ack_o |-> slave_select_used_o == (c1[7] && !c1[5] && !frame_cfg_o.framed_enable);
   endproperty
   property p_edge;
      !ack_o |-> edge_select_o == (c1[8] && !frame_cfg_o.framed_enable);
   endproperty
   property p_frame; ack_o && we_i && adr_i == 4'h4 |=> $stable(frame_cfg_o)[*3]; endproperty
   property p_period; $rose(sck_o) && seen |-> cnt == ratio; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   a_ack_one: assert property (p_ack_one) else $error("ack too long");
   a_idle: assert property (p_idle) else $error("idle level wrong");
   a_oe: assert property (p_oe) else $error("clock drive wrong");
   a_ss: assert property (p_ss) else $error("select use wrong");
   a_edge: assert property (p_edge) else $error("edge select wrong");
   a_frame: assert property (p_frame) else $error("frame fields moved");
   a_period: assert property (p_period) else $error("clock period wrong");
endmodule
bind spi_clock_and_frame_control spi_clock_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
   .port_enable_i(port_enable_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
   .slave_select_used_o(slave_select_used_o), .edge_select_o(edge_select_o),
   .frame_cfg_o(frame_cfg_o)
);

/* verif/tb.sv */
/* Self-checking bench for the serial clock and frame control block.
   Assumes the bound checker watches timing and the peer clocks slave mode. */
`timescale 1ns/1ps
module tb;
   import spi_clock_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, en = 1'b0, run = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 32'h0, dat_o, q;
   logic ack, sck_i, sck, oe, ss, edge_sel;
   frame_cfg_s fcfg;
   int num_errors = 0, checks = 0;
   spi_clock_and_frame_control uut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .port_enable_i(en),
      .sck_i(sck_i), .sck_o(sck), .sck_oe_o(oe), .slave_select_used_o(ss),
      .edge_select_o(edge_sel), .frame_cfg_o(fcfg)
   );
   spi_link_peer peer (.clk_i(clk_i), .run_i(run), .idle_i(1'b0), .sck_o(sck_i));
   task automatic close_out;
      if (num_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, s};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n == 50) chk("ack", 32'h1, 32'(ack));
      q = dat_o;
      {cyc, stb} <= 2'b00;
   endtask
   initial forever #5 clk_i = !clk_i;
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      close_out();
   end
   initial begin
      int r;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 4'h0, 32'h0, 4'h3);
      chk("ctrl_one", 32'h0, q);
      wb(1'b1, 4'h4, 32'hffff, 4'h3);
      wb(1'b0, 4'h4, 32'h0, 4'h3);
      chk("ctrl_two", 32'he002, q);
      chk("frame_cfg", 32'hf, 32'(fcfg));
      wb(1'b1, 4'h4, 32'h0, 4'h3);
      wb(1'b0, 4'hc, 32'h0, 4'h3);
      chk("unmapped", 32'h0, q);
      for (int p = 0; p < 4; p++) begin
         for (int s = 0; s < 8; s++) begin
            if (p == 3 && s == 7) continue;
            en <= 1'b0;
            wb(1'b1, 4'h0, 32'(s * 4 + p + 32 + (s % 2) * 64), 4'h1);
            repeat (4) @(posedge clk_i);
            chk("sck_idle", 32'(s % 2), 32'(sck));
            en <= 1'b1;
            r = (1 << (2 * (3 - p))) * (8 - s);
            repeat (2 * r + 20) @(posedge clk_i);
            chk("sck_oe", 32'h1, 32'(oe));
            wb(1'b0, 4'h8, 32'h0, 4'h3);
            chk("ratio", 32'(r), q & 32'h3ff);
         end
      end
      en <= 1'b0;
      wb(1'b1, 4'h0, 32'h3f, 4'h1);
      en <= 1'b1;
      repeat (10) @(posedge clk_i);
      wb(1'b0, 4'h8, 32'h0, 4'h3);
      chk("status", 32'h3001, q);
      chk("sck_held", 32'h0, 32'(sck));
      en <= 1'b0;
      wb(1'b1, 4'h0, 32'h180, 4'h3);
      en <= 1'b1;
      run <= 1'b1;
      repeat (40) @(posedge clk_i);
      chk("sck_oe", 32'h0, 32'(oe));
      chk("ss_used", 32'h1, 32'(ss));
      chk("edge_sel", 32'h1, 32'(edge_sel));
      wb(1'b1, 4'h0, 32'h100, 4'h3);
      wb(1'b1, 4'h4, 32'h8000, 4'h3);
      @(posedge clk_i);
      chk("edge_sel", 32'h0, 32'(edge_sel));
      chk("ss_used", 32'h0, 32'(ss));
      run <= 1'b0;
      close_out();
   end
endmodule
